/* hw/expander_pkg.sv */
// Shared constants of the I2C port expander core.
// Assumes a single 250 MHz core clock.
package expander_pkg;
  localparam int CLOCK_PERIOD_NS = 4;
  // Spike suppression on SCL and SDA
  localparam int FILTER_NS = 50;
  localparam int FILTER_CYCLES =
    (FILTER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int PINS = 16;

  // Responder addressing
  localparam logic [6:0] ADDR_BASE = 7'h20;
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] SW_RESET_CMD = 8'h06;

  // Command byte values
  localparam logic [7:0] CMD_IN0 = 8'h00;
  localparam logic [7:0] CMD_IN1 = 8'h01;
  localparam logic [7:0] CMD_OUT0 = 8'h02;
  localparam logic [7:0] CMD_OUT1 = 8'h03;
  localparam logic [7:0] CMD_POL0 = 8'h04;
  localparam logic [7:0] CMD_POL1 = 8'h05;
  localparam logic [7:0] CMD_CFG0 = 8'h06;
  localparam logic [7:0] CMD_CFG1 = 8'h07;
  localparam logic [7:0] CMD_DRV0 = 8'h40;
  localparam logic [7:0] CMD_DRV1 = 8'h41;
  localparam logic [7:0] CMD_DRV2 = 8'h42;
  localparam logic [7:0] CMD_DRV3 = 8'h43;
  localparam logic [7:0] CMD_MASK0 = 8'h4a;
  localparam logic [7:0] CMD_MASK1 = 8'h4b;
  localparam logic [7:0] CMD_STAT0 = 8'h4c;
  localparam logic [7:0] CMD_STAT1 = 8'h4d;

  // Reset values
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [15:0] OUT_RST = 16'hffff;
  localparam logic [15:0] POL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'hffff;
  localparam logic [31:0] DRV_RST = 32'hffffffff;
  localparam logic [15:0] MASK_RST = 16'hffff;
endpackage

/* hw/line_filter.sv */
// Two-stage synchroniser followed by a stability filter for one bus line.
// Assumes an idle-high open-drain line sampled on the core clock.
`timescale 1ns/1ps
`default_nettype none
module line_filter #(
  parameter int STABLE_CYCLES = 13
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic line_in,
  output logic line_out
);
  logic meta;
  logic sync;
  logic [7:0] count;
  wire differs = sync != line_out;
  wire settled = count >= 8'(STABLE_CYCLES - 1);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta <= 1'b1;
      sync <= 1'b1;
    end else begin
      meta <= line_in;
      sync <= meta;
    end
  end

  // Spikes shorter than the window never reach the output
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= 8'h00;
      line_out <= 1'b1;
    end else if (!differs) begin
      count <= 8'h00;
    end else if (settled) begin
      count <= 8'h00;
      line_out <= sync;
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* hw/i2c_gpio_expander_core.sv */
// Control core of a 16-bit I2C port expander: responder, registers,
// pin drivers and change-detect interrupt.
// Assumes reset_n is the power-on reset; all pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module i2c_gpio_expander_core
  import expander_pkg::*;
#(
  parameter int FILTER_LEN = expander_pkg::FILTER_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reset_pin_n,
  input wire logic addr_sel,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq_out,
  output logic irq_oe_n,
  input wire logic [expander_pkg::PINS-1:0] port_in,
  output logic [expander_pkg::PINS-1:0] port_out,
  output logic [expander_pkg::PINS-1:0] port_oe_n,
  output logic [4*expander_pkg::PINS-1:0] high_side_driver,
  output logic [4*expander_pkg::PINS-1:0] low_side_driver
);
  import expander_pkg::*;

  typedef enum logic [2:0] {
    st_idle, st_addr, st_rx, st_ack, st_tx, st_rack, st_ignore
  } resp_state_t;

  // Drive code to finger enables; code 01 gives two of four
  function automatic logic [3:0] fingers(input logic [1:0] code);
    case (code)
      2'b00: fingers = 4'h1;
      2'b01: fingers = 4'h3;
      2'b10: fingers = 4'h7;
      default: fingers = 4'hf;
    endcase
  endfunction

  // Pin synchronisers
  logic [PINS-1:0] pin_meta;
  logic [PINS-1:0] live;
  logic addr_meta;
  logic addr_sync;
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= '0;
      live <= '0;
      addr_meta <= 1'b0;
      addr_sync <= 1'b0;
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      pin_meta <= port_in;
      live <= pin_meta;
      addr_meta <= addr_sel;
      addr_sync <= addr_meta;
      rst_meta <= reset_pin_n;
      rst_sync <= rst_meta;
    end
  end

  // Filtered bus lines
  logic scl_f;
  logic sda_f;
  logic scl_q;
  logic sda_q;

  line_filter #(.STABLE_CYCLES(FILTER_LEN)) u_scl_filter (
    .clock(clock),
    .reset_n(reset_n),
    .line_in(scl_in),
    .line_out(scl_f)
  );

  line_filter #(.STABLE_CYCLES(FILTER_LEN)) u_sda_filter (
    .clock(clock),
    .reset_n(reset_n),
    .line_in(sda_in),
    .line_out(sda_f)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  wire scl_rise = scl_f && !scl_q;
  wire scl_fall = !scl_f && scl_q;
  wire start_seen = scl_f && scl_q && sda_q && !sda_f;
  wire stop_seen = scl_f && scl_q && !sda_q && sda_f;

  // Responder state
  resp_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [7:0] ptr;
  logic read_mode;
  logic gen_call;
  logic first_byte;
  logic sw_pend;
  logic sw_fire;

  // Register file
  logic [15:0] out_reg;
  logic [15:0] pol_reg;
  logic [15:0] cfg_reg;
  logic [31:0] drv_reg;
  logic [15:0] mask_reg;
  logic [15:0] in_reg;
  logic load_live;

  // Hardware pin or completed software reset
  wire clr = !rst_sync || sw_fire;

  // Address decode; select must not move inside a frame
  wire [6:0] dev_addr = {ADDR_BASE[6:1], addr_sync};
  wire byte_done = scl_fall && bit_cnt == 4'd8;
  wire addr_match = shift[7:1] == dev_addr;
  wire gc_write = shift == GC_ADDR;
  wire data_ok = !gen_call || (first_byte && shift == SW_RESET_CMD);
  wire wr_en = state == st_rx && byte_done && !gen_call && !first_byte;
  wire ack_slot = state == st_rack && scl_rise;

  // Interrupt source: live level against stored input, inputs only
  wire [15:0] change = (live ^ in_reg) & cfg_reg;
  wire [15:0] pending = change & ~mask_reg;
  wire irq_any = |pending;

  logic [7:0] rd_data;
  always_comb begin
    case (ptr)
      CMD_IN0: rd_data = live[7:0] ^ pol_reg[7:0];
      CMD_IN1: rd_data = live[15:8] ^ pol_reg[15:8];
      CMD_OUT0: rd_data = out_reg[7:0];
      CMD_OUT1: rd_data = out_reg[15:8];
      CMD_POL0: rd_data = pol_reg[7:0];
      CMD_POL1: rd_data = pol_reg[15:8];
      CMD_CFG0: rd_data = cfg_reg[7:0];
      CMD_CFG1: rd_data = cfg_reg[15:8];
      CMD_DRV0: rd_data = drv_reg[7:0];
      CMD_DRV1: rd_data = drv_reg[15:8];
      CMD_DRV2: rd_data = drv_reg[23:16];
      CMD_DRV3: rd_data = drv_reg[31:24];
      CMD_MASK0: rd_data = mask_reg[7:0];
      CMD_MASK1: rd_data = mask_reg[15:8];
      CMD_STAT0: rd_data = pending[7:0];
      CMD_STAT1: rd_data = pending[15:8];
      default: rd_data = 8'h00;
    endcase
  end

  // Responder sequencing
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= st_idle;
      shift <= 8'h00;
      bit_cnt <= 4'd0;
      ptr <= PTR_RST;
      read_mode <= 1'b0;
      gen_call <= 1'b0;
      first_byte <= 1'b0;
      sw_pend <= 1'b0;
      sw_fire <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sw_fire <= 1'b0;
      if (clr) begin
        state <= st_idle;
        bit_cnt <= 4'd0;
        ptr <= PTR_RST;
        sw_pend <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (stop_seen) begin
        sw_fire <= sw_pend;
        sw_pend <= 1'b0;
        state <= st_idle;
        sda_oe_n <= 1'b1;
      end else if (start_seen) begin
        // Repeated START drops a half-finished software reset
        sw_pend <= 1'b0;
        state <= st_addr;
        bit_cnt <= 4'd0;
        sda_oe_n <= 1'b1;
      end else begin
        case (state)
          st_addr, st_rx: begin
            if (scl_rise && bit_cnt != 4'd8) begin
              shift <= {shift[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'd1;
            end else if (byte_done && state == st_addr) begin
              first_byte <= 1'b1;
              if (addr_match || gc_write) begin
                read_mode <= addr_match && shift[0];
                gen_call <= !addr_match;
                sda_oe_n <= 1'b0;
                state <= st_ack;
              end else begin
                state <= st_ignore;
              end
            end else if (byte_done) begin
              first_byte <= 1'b0;
              if (data_ok) begin
                sda_oe_n <= 1'b0;
                state <= st_ack;
                sw_pend <= gen_call;
                if (!gen_call && first_byte) begin
                  ptr <= shift;
                end else if (!gen_call) begin
                  ptr <= {ptr[7:1], ~ptr[0]};
                end
              end else begin
                sw_pend <= 1'b0;
                state <= st_ignore;
              end
            end
          end
          st_ack: begin
            if (scl_fall) begin
              bit_cnt <= 4'd0;
              if (read_mode) begin
                shift <= {rd_data[6:0], 1'b0};
                sda_oe_n <= rd_data[7];
                state <= st_tx;
              end else begin
                sda_oe_n <= 1'b1;
                state <= st_rx;
              end
            end
          end
          st_tx: begin
            if (scl_fall && bit_cnt == 4'd7) begin
              sda_oe_n <= 1'b1;
              state <= st_rack;
            end else if (scl_fall) begin
              sda_oe_n <= shift[7];
              shift <= {shift[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'd1;
            end
          end
          st_rack: begin
            if (scl_rise) begin
              ptr <= {ptr[7:1], ~ptr[0]};
              // Controller NACK ends the read; SDA stays released
              state <= sda_f ? st_ignore : st_ack;
              read_mode <= 1'b1;
            end
          end
          st_ignore: begin
            sda_oe_n <= 1'b1;
          end
          default: begin
            state <= st_idle;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // Read ack in st_ack re-enters a byte without driving the slot
  // because sda_oe_n was released on the final bit.

  // Configuration registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      out_reg <= OUT_RST;
      pol_reg <= POL_RST;
      cfg_reg <= CFG_RST;
      drv_reg <= DRV_RST;
      mask_reg <= MASK_RST;
    end else if (clr) begin
      out_reg <= OUT_RST;
      pol_reg <= POL_RST;
      cfg_reg <= CFG_RST;
      drv_reg <= DRV_RST;
      mask_reg <= MASK_RST;
    end else if (wr_en) begin
      case (ptr)
        CMD_OUT0: out_reg[7:0] <= shift;
        CMD_OUT1: out_reg[15:8] <= shift;
        CMD_POL0: pol_reg[7:0] <= shift;
        CMD_POL1: pol_reg[15:8] <= shift;
        CMD_CFG0: cfg_reg[7:0] <= shift;
        CMD_CFG1: cfg_reg[15:8] <= shift;
        CMD_DRV0: drv_reg[7:0] <= shift;
        CMD_DRV1: drv_reg[15:8] <= shift;
        CMD_DRV2: drv_reg[23:16] <= shift;
        CMD_DRV3: drv_reg[31:24] <= shift;
        CMD_MASK0: mask_reg[7:0] <= shift;
        CMD_MASK1: mask_reg[15:8] <= shift;
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  // Stored input levels. A read clears its port at the ACK rising
  // edge; a change landing in that same cycle is absorbed, which is
  // the documented loss window.
  wire rd_port0 = ack_slot && ptr == CMD_IN0;
  wire rd_port1 = ack_slot && ptr == CMD_IN1;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      in_reg <= 16'h0000;
      load_live <= 1'b1;
    end else begin
      load_live <= clr;
      if (load_live || clr) begin
        in_reg <= live;
      end else begin
        if (rd_port0) begin
          in_reg[7:0] <= live[7:0];
        end
        if (rd_port1) begin
          in_reg[15:8] <= live[15:8];
        end
      end
    end
  end

  // Pin drivers, registered so nothing glitches on the pads
  logic [4*PINS-1:0] next_high;
  logic [4*PINS-1:0] next_low;
  always_comb begin
    next_high = '0;
    next_low = '0;
    for (int i = 0; i < PINS; i++) begin
      if (!cfg_reg[i] && out_reg[i]) begin
        next_high[4*i +: 4] = fingers(drv_reg[2*i +: 2]);
      end else if (!cfg_reg[i]) begin
        next_low[4*i +: 4] = fingers(drv_reg[2*i +: 2]);
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port_out <= OUT_RST;
      port_oe_n <= '1;
      high_side_driver <= '0;
      low_side_driver <= '0;
      irq_oe_n <= 1'b1;
      irq_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      port_out <= out_reg;
      port_oe_n <= cfg_reg;
      high_side_driver <= next_high;
      low_side_driver <= next_low;
      irq_oe_n <= !irq_any || clr;
      irq_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* sim/i2c_host_model.sv */
// Behavioural I2C bus controller driving SCL and the SDA pull-down.
// Assumes the bench resolves the open-drain SDA line with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // 20-cycle quarters keep each SCL phase at 40 cycles, over the filter
  task automatic qt(int n);
    repeat (20 * n) @(posedge clock);
    #1;
  endtask
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic start();
    qt(1);
    sda_drv = 1'b1;
    qt(1);
    scl = 1'b1;
    qt(2);
    sda_drv = 1'b0;
    qt(2);
    scl = 1'b0;
  endtask
  task automatic stop();
    qt(1);
    sda_drv = 1'b0;
    qt(1);
    scl = 1'b1;
    qt(2);
    sda_drv = 1'b1;
    qt(2);
  endtask
  // Eight bits MSB first, then our own level in the ninth slot
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic k);
    logic [8:0] w;
    w = {d, a};
    for (int i = 8; i >= 0; i--) begin
      qt(1);
      sda_drv = w[i];
      qt(1);
      scl = 1'b1;
      qt(2);
      if (i > 0)
        q[i-1] = sda_line;
      else
        k = sda_line;
      scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* sim/expander_properties.sv */
// Concurrent checks on the expander core's ports.
// Assumes one clock domain; bound to every core instance.
`timescale 1ns/1ps
`default_nettype none
module expander_properties
  import expander_pkg::*;
#(
  parameter int FILTER_LEN = 13
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reset_pin_n,
  input wire logic addr_sel,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  input wire logic [PINS-1:0] port_in,
  input wire logic [PINS-1:0] port_out,
  input wire logic [PINS-1:0] port_oe_n,
  input wire logic [4*PINS-1:0] high_side_driver,
  input wire logic [4*PINS-1:0] low_side_driver
);
  logic [4*PINS-1:0] oe4, out4;
  logic [PINS-1:0] any_on;
  for (genvar i = 0; i < PINS; i++) begin : g_pin
    assign oe4[4*i+:4] = {4{port_oe_n[i]}};
    assign out4[4*i+:4] = {4{port_out[i]}};
    assign any_on[i] = |(high_side_driver[4*i+:4] | low_side_driver[4*i+:4]);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence ack_begin;
    $fell(sda_oe_n) && !scl_in;
  endsequence
  // Fingers and direction are registered in the same stage and change together
  sequence pins_settled;
    ($stable(port_oe_n) && $stable(port_out)) [*2];
  endsequence
  a_irq_data_low: assert property (irq_out == 1'b0)
    else $error("interrupt data not low");
  a_sda_data_low: assert property (sda_out == 1'b0)
    else $error("sda data not low");
  a_input_no_drive: assert property (pins_settled |->
    ((high_side_driver | low_side_driver) & oe4) == '0)
    else $error("input pin driven");
  a_output_level: assert property (pins_settled |->
    (high_side_driver & ~out4) == '0 && (low_side_driver & out4) == '0)
    else $error("output pin driven to wrong level");
  a_output_has_finger: assert property (pins_settled |->
    (any_on | port_oe_n) == '1)
    else $error("output pin with no finger on");
  a_sda_moves_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda changed while scl high");
  a_ack_stands: assert property (ack_begin |-> ##1 !sda_oe_n [*8])
    else $error("sda pull-down too short");
  a_pin_reset_dflt: assert property (!reset_pin_n [*5] |->
    port_oe_n == '1 && port_out == '1 && irq_oe_n && sda_oe_n)
    else $error("reset pin low but outputs not default");
  a_por_release: assert property ($rose(reset_n) |->
    port_oe_n == '1 && high_side_driver == '0 && irq_oe_n && sda_oe_n)
    else $error("outputs not default after power-on release");
  a_outputs_quiet: assert property (port_oe_n == '0 [*8] |-> irq_oe_n)
    else $error("interrupt with all pins output");
endmodule
bind i2c_gpio_expander_core expander_properties #(.FILTER_LEN(FILTER_LEN))
  u_props (
  .clock(clock), .reset_n(reset_n), .reset_pin_n(reset_pin_n),
  .addr_sel(addr_sel), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq_out(irq_out),
  .irq_oe_n(irq_oe_n), .port_in(port_in), .port_out(port_out),
  .port_oe_n(port_oe_n), .high_side_driver(high_side_driver),
  .low_side_driver(low_side_driver)
);
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the port expander core.
// Assumes the controller model and the bound property checker.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import expander_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic addr_sel = 1'b0;
  logic [15:0] port_in = 16'h0000;
  logic scl, sda_drv, sda_out, sda_oe_n, irq_out, irq_oe_n;
  logic [15:0] port_out, port_oe_n, o, c, v;
  logic [63:0] hs, ls, e;
  logic [31:0] d;
  logic [7:0] q;
  logic [6:0] dev = ADDR_BASE;
  int failures = 0;
  int n_compared = 0;
  int b;
  wire logic sda;
  assign sda = sda_drv & (sda_oe_n | sda_out);
  always #2 clock = ~clock;
  // Short filter keeps the bus slow enough yet the run brief
  i2c_gpio_expander_core #(.FILTER_LEN(2)) u_dut (
    .clock(clock), .reset_n(reset_n), .reset_pin_n(reset_pin_n),
    .addr_sel(addr_sel), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
    .port_in(port_in), .port_out(port_out), .port_oe_n(port_oe_n),
    .high_side_driver(hs), .low_side_driver(ls)
  );
  i2c_host_model u_host (
    .clock(clock), .sda_line(sda), .scl(scl), .sda_drv(sda_drv)
  );
  task automatic cy(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [63:0] nf(logic on, logic [1:0] code);
    return on ? 64'(code) + 64'h1 : 64'h0;
  endfunction
  task automatic xb(logic [7:0] x, logic a, logic ex);
    logic k;
    u_host.xfer(x, a, q, k);
    chk("ack", k, ex);
  endtask
  task automatic wr(logic [7:0] cmd, logic [15:0] x);
    u_host.start();
    xb({dev, 1'b0}, 1'b1, 1'b0);
    xb(cmd, 1'b1, 1'b0);
    xb(x[7:0], 1'b1, 1'b0);
    xb(x[15:8], 1'b1, 1'b0);
    u_host.stop();
  endtask
  task automatic rd(logic [7:0] cmd, logic setp);
    if (setp) begin
      u_host.start();
      xb({dev, 1'b0}, 1'b1, 1'b0);
      xb(cmd, 1'b1, 1'b0);
    end
    u_host.start();
    xb({dev, 1'b1}, 1'b1, 1'b0);
    xb(8'hff, 1'b0, 1'b0);
    v[7:0] = q;
    xb(8'hff, 1'b1, 1'b1);
    v[15:8] = q;
    u_host.stop();
  endtask
  task automatic gc(logic [7:0] x, logic ex);
    u_host.start();
    xb(GC_ADDR, 1'b1, 1'b0);
    xb(x, 1'b1, ex);
  endtask
  // Bounded wait; a miss ends the run at once
  task automatic irq_is(logic ex);
    for (int k = 0; k < 12 && irq_oe_n !== ex; k++)
      cy(1);
    chk("irq_oe_n", irq_oe_n, ex);
    if (irq_oe_n !== ex)
      give_verdict();
  endtask
  initial begin
    void'($urandom(32'h2e99));
    cy(20);
    reset_n = 1'b1;
    cy(20);
    chk("oe_n", port_oe_n, CFG_RST);
    chk("out", port_out, OUT_RST);
    chk("fingers", hs | ls, 64'h0);
    chk("irq", {irq_out, irq_oe_n}, 2'b01);
    $display("test reset_defaults done");
    for (int s = 0; s < 2; s++) begin
      addr_sel = s[0];
      dev = ADDR_BASE | 7'(s);
      cy(10);
      u_host.start();
      xb({dev ^ 7'h02, 1'b0}, 1'b1, 1'b1);
      u_host.start();
      xb({dev, 1'b0}, 1'b1, 1'b0);
      u_host.stop();
    end
    $display("test address done");
    for (int n = 0; n < 2; n++) begin
      o = 16'($urandom);
      c = n == 0 ? 16'h0000 : 16'($urandom);
      d = n == 0 ? 32'h5555_5555 : $urandom;
      wr(CMD_OUT0, o);
      wr(CMD_DRV0, d[15:0]);
      wr(CMD_DRV2, d[31:16]);
      wr(CMD_CFG0, c);
      cy(4);
      chk("oe_n", port_oe_n, c);
      chk("out", port_out, o);
      for (int i = 0; i < PINS; i++) begin
        e = nf(!c[i] && o[i], d[2*i+:2]);
        chk("high", 64'($countones(hs[4*i+:4])), e);
        e = nf(!c[i] && !o[i], d[2*i+:2]);
        chk("low", 64'($countones(ls[4*i+:4])), e);
      end
      rd(CMD_OUT0, 1'b1);
      chk("read_out", v, o);
    end
    $display("test drive done");
    wr(CMD_CFG0, 16'hffff);
    wr(CMD_MASK0, 16'h0000);
    for (int n = 0; n < 3; n++) begin
      b = n == 0 ? 15 : $urandom_range(14, 0);
      port_in[b] = ~port_in[b];
      irq_is(1'b0);
      port_in[b] = ~port_in[b];
      irq_is(1'b1);
      port_in[b] = ~port_in[b];
      irq_is(1'b0);
      u_host.start();
      xb({dev ^ 7'h02, 1'b1}, 1'b1, 1'b1);
      u_host.stop();
      irq_is(1'b0);
      rd(b < 8 ? CMD_IN0 : CMD_IN1, 1'b1);
      irq_is(1'b1);
    end
    wr(CMD_MASK0, 16'h0001);
    port_in[0] = ~port_in[0];
    cy(12);
    chk("irq_masked", irq_oe_n, 1'b1);
    port_in[0] = ~port_in[0];
    wr(CMD_MASK0, 16'h0000);
    wr(CMD_CFG0, 16'hfffe);
    port_in[0] = ~port_in[0];
    cy(12);
    chk("irq_output", irq_oe_n, 1'b1);
    wr(CMD_CFG0, 16'hffff);
    irq_is(1'b0);
    $display("test interrupt done");
    wr(CMD_CFG0, 16'h00ff);
    reset_pin_n = 1'b0;
    port_in = 16'($urandom);
    cy(6);
    chk("oe_n", port_oe_n, CFG_RST);
    chk("out", port_out, OUT_RST);
    chk("irq", irq_oe_n, 1'b1);
    reset_pin_n = 1'b1;
    cy(4);
    wr(CMD_MASK0, 16'h0000);
    cy(12);
    chk("irq_refresh", irq_oe_n, 1'b1);
    $display("test reset_pin done");
    wr(CMD_CFG0, 16'h0000);
    u_host.start();
    xb({GC_ADDR[7:1], 1'b1}, 1'b1, 1'b1);
    gc(8'h07, 1'b1);
    gc(SW_RESET_CMD, 1'b0);
    xb(SW_RESET_CMD, 1'b1, 1'b1);
    u_host.stop();
    gc(SW_RESET_CMD, 1'b0);
    u_host.start();
    u_host.stop();
    cy(4);
    chk("oe_n", port_oe_n, 16'h0000);
    gc(SW_RESET_CMD, 1'b0);
    u_host.stop();
    cy(4);
    chk("oe_n", port_oe_n, CFG_RST);
    chk("out", port_out, OUT_RST);
    // No write since the reset, so the pointer must still be zero
    rd(CMD_IN0, 1'b0);
    chk("pointer", v, port_in);
    $display("test software_reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
